// ### logic/pts_consts.svh
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

// bus command codes
`define PTS_CMD_IO_RD       4'h2
`define PTS_CMD_IO_WR       4'h3
`define PTS_CMD_MEM_RD      4'h6
`define PTS_CMD_MEM_WR      4'h7
`define PTS_CMD_CFG_RD      4'ha
`define PTS_CMD_CFG_WR      4'hb
`define PTS_CMD_MEM_RD_MULT 4'hc
`define PTS_CMD_MEM_RD_LINE 4'he
`define PTS_CMD_MEM_WR_INV  4'hf

// configuration space offsets (dword indices)
`define PTS_CFG_ID          6'h00
`define PTS_CFG_CMDSTAT     6'h01
`define PTS_CFG_IOBAR       6'h04
`define PTS_CFG_MEMBAR      6'h05

// field positions
`define PTS_CMD_IO_SPACE_ENABLE_BIT    0
`define PTS_CMD_MEMORY_SPACE_ENABLE_BIT   1
`define PTS_STAT_FBB_BIT    23
`define PTS_DWORD_IO_MODE_BIT        28

// window sizes, as address bit counts
`define PTS_IO_WIN_BITS     5
`define PTS_MEM_WIN_BITS    12

// register offsets inside the window
`define PTS_SOFT_RESET_OFS  12'h014
`define PTS_SOFT_RESET_DW   12'h018
`define PTS_INDIRECT_LIMIT  12'h020

// timing counts in clocks
`define PTS_BUSY_LIMIT      5'd16
`define PTS_CFG_TRDY_DLY    3'd2

// reset values
`define PTS_CMD_RESET       2'h0
`define PTS_BAR_RESET       32'h0000_0000

`endif

// ### logic/pts_pkg.sv
package pts_pkg;
    typedef enum logic [5:0] {
        PTS_IDLE  = 6'b000001,
        PTS_DECOD = 6'b000010,
        PTS_WAIT  = 6'b000100,
        PTS_DATA  = 6'b001000,
        PTS_STOP  = 6'b010000,
        PTS_TURN  = 6'b100000
    } pts_state_t;

    typedef enum logic [1:0] {
        PTS_SP_CFG = 2'h0,
        PTS_SP_IO  = 2'h1,
        PTS_SP_MEM = 2'h2
    } pts_space_t;
endpackage

// ### logic/pts_sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser for a pin level
module pts_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // first stage feeds only the second
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d_in;
            q_ff    <= meta_ff;
        end
    end

    assign q_out = q_ff;
endmodule

// ### logic/pts_target.sv
`timescale 1ns/1ps
`include "pts_consts.svh"

//
// Notes on behaviour
// - claim io reads and io writes of all registers, including the reset register
// - memory read and write serve memory mapped register accesses
// - configuration read and write reach the configuration space
// - memory read multiple/line act as read, write invalidate acts as write
// - never claim a matching address with an unfitting command code
// - config claim needs idsel, config command and low address bits zero
// - config dword from address 7:2, bits 10:8 zero, 31:11 ignored
// - byte enables pick active bytes; 8, 16 and 32 bit transfers
// - devsel asserts two clocks after frame on every claimed cycle
// - config cycles fixed length, trdy on third data clock
// - config burst is disconnected after first data phase
// - config access during eeprom load ends with retry
// - fast back-to-back bit reads one; back-to-back address phase decoded
// - io or memory decode only after its space enable is set
// - io mode claims a 32-byte window at the io base
// - memory mode claims a 4096-byte window at the memory base
// - all 32 address lines decide the internal resource
// - lowest 32 offsets disconnect bursts; higher offsets may burst
// - reset register read has a side effect; host must not prefetch there
// - slave wait states vary and are supplied by the register back end
// - access longer than 16 clocks gives retry with devsel held
// - burst disconnect asserts stop together with trdy
// - during eeprom load stop with devsel, trdy high, until cycle ends
module pts_target (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    input  wire logic        idsel,
    input  wire logic [3:0]  cbe_n,
    input  wire logic [31:0] ad_in,
    output logic      [31:0] ad_out,
    output logic             ad_oe_n,
    output logic             devsel_n_out,
    output logic             devsel_oe_n,
    output logic             trdy_n_out,
    output logic             trdy_oe_n,
    output logic             stop_n_out,
    output logic             stop_oe_n,
    input  wire logic        eeprom_busy,
    output logic             reg_req,
    output logic             reg_wr,
    output logic             reg_mem,
    output logic [11:0]      reg_addr,
    output logic [3:0]       reg_be,
    output logic [31:0]      reg_wdata,
    input  wire logic        reg_ack,
    input  wire logic [31:0] reg_rdata,
    output logic             soft_reset_trigger,
    output logic             io_space_enable,
    output logic             memory_space_enable,
    input  wire logic        dword_io_mode
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic        frame_s;
    logic        irdy_s;
    logic        idsel_s;
    logic        ee_s;
    logic [3:0]  cbe_s;
    logic [31:0] ad_s;

    pts_sync2 #(.W(40)) u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .d_in    ({~frame_n, ~irdy_n, idsel, eeprom_busy, ~cbe_n, ad_in}),
        .q_out   ({frame_s, irdy_s, idsel_s, ee_s, cbe_s, ad_s})
    );

    // ----------------------------------------------------------------
    // state declarations
    // ----------------------------------------------------------------
    pts_pkg::pts_state_t st_ff, nxt_st;
    pts_pkg::pts_space_t sp_ff, nxt_sp;
    logic        frame_d_ff, nxt_frame_d;
    logic        wr_ff, nxt_wr;
    logic [11:0] ofs_ff, nxt_ofs;
    logic [4:0]  cnt_ff, nxt_cnt;
    logic        retry_ff, nxt_retry;
    logic        disc_ff, nxt_disc;
    logic [1:0]  cmd_ff, nxt_cmd;
    logic [31:0] iobar_ff, nxt_iobar;
    logic [31:0] membar_ff, nxt_membar;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        devsel_ff, nxt_devsel;
    logic        trdy_ff, nxt_trdy;
    logic        stop_ff, nxt_stop;
    logic        oe_ff, nxt_oe;
    logic        srst_ff, nxt_srst;

    // ----------------------------------------------------------------
    // address phase decode
    // ----------------------------------------------------------------
    logic        addr_phase;
    logic        is_cfg, is_io, is_mem, io_hit, mem_hit, cfg_hit, rd_cmd;
    logic [3:0]  cmd;

    // address phase is a fresh frame edge, even right after another target
    // back-to-back decode
    assign addr_phase = frame_s && !frame_d_ff && st_ff == pts_pkg::PTS_IDLE;
    assign cmd        = ~cbe_s;  // command code is the raw pin level, not inverted
    assign is_mem = cmd == `PTS_CMD_MEM_RD || cmd == `PTS_CMD_MEM_RD_MULT || cmd == `PTS_CMD_MEM_RD_LINE
                 || cmd == `PTS_CMD_MEM_WR || cmd == `PTS_CMD_MEM_WR_INV;
    assign is_io  = cmd == `PTS_CMD_IO_RD || cmd == `PTS_CMD_IO_WR;
    assign is_cfg = cmd == `PTS_CMD_CFG_RD || cmd == `PTS_CMD_CFG_WR;
    assign rd_cmd = !cmd[0];
    assign cfg_hit = idsel_s && is_cfg && ad_s[1:0] == 2'h0 && ad_s[10:8] == 3'h0;
    // io window on all 32 lines
    assign io_hit  = cmd_ff[`PTS_CMD_IO_SPACE_ENABLE_BIT] && is_io
                  && ad_s[31:`PTS_IO_WIN_BITS] == iobar_ff[31:`PTS_IO_WIN_BITS];
    assign mem_hit = cmd_ff[`PTS_CMD_MEMORY_SPACE_ENABLE_BIT] && is_mem
                  && ad_s[31:`PTS_MEM_WIN_BITS] == membar_ff[31:`PTS_MEM_WIN_BITS];

    // ----------------------------------------------------------------
    // transaction state machine
    // ----------------------------------------------------------------
    // next state and bus outputs, registered below
    always_comb begin
        nxt_st      = st_ff;
        nxt_sp      = sp_ff;
        nxt_frame_d = frame_s;
        nxt_wr      = wr_ff;
        nxt_ofs     = ofs_ff;
        nxt_cnt     = cnt_ff;
        nxt_retry   = retry_ff;
        nxt_disc    = disc_ff;
        nxt_cmd     = cmd_ff;
        nxt_iobar   = iobar_ff;
        nxt_membar  = membar_ff;
        nxt_rdata   = rdata_ff;
        nxt_devsel  = devsel_ff;
        nxt_trdy    = 1'b0;
        nxt_stop    = stop_ff;
        nxt_oe      = oe_ff;
        nxt_srst    = 1'b0;
        case (st_ff)
            pts_pkg::PTS_IDLE: begin
                nxt_cnt = 5'd0;
                if (addr_phase && (cfg_hit || io_hit || mem_hit)) begin
                    nxt_st    = pts_pkg::PTS_DECOD;
                    nxt_sp    = cfg_hit ? pts_pkg::PTS_SP_CFG : (io_hit ? pts_pkg::PTS_SP_IO : pts_pkg::PTS_SP_MEM);
                    nxt_wr    = !rd_cmd;
                    // io offset is kept inside the 32-byte window, base bits dropped
                    nxt_ofs   = cfg_hit ? {4'h0, ad_s[7:2], 2'h0} : (io_hit ? {7'h0, ad_s[4:0]} : ad_s[11:0]);
                    nxt_retry = ee_s;
                end
            end
            pts_pkg::PTS_DECOD: begin
                // devsel on second clock after frame
                nxt_devsel = 1'b1;
                nxt_oe     = !wr_ff;
                nxt_st     = pts_pkg::PTS_WAIT;
                // no burst in config or low offsets
                nxt_disc   = sp_ff == pts_pkg::PTS_SP_CFG || ofs_ff < `PTS_INDIRECT_LIMIT;
            end
            pts_pkg::PTS_WAIT: begin
                nxt_cnt = cnt_ff + 5'd1;
                if (retry_ff) begin
                    // stop with devsel, trdy held off
                    nxt_stop = 1'b1;
                    nxt_st   = pts_pkg::PTS_STOP;
                end else if (cnt_ff == `PTS_BUSY_LIMIT - 5'd2) begin
                    nxt_stop = 1'b1;
                    nxt_st   = pts_pkg::PTS_STOP;
                end else if (sp_ff == pts_pkg::PTS_SP_CFG) begin
                    // fixed length config, trdy on third data clock
                    if (cnt_ff == {2'h0, `PTS_CFG_TRDY_DLY} - 5'd1 && irdy_s) begin
                        nxt_trdy = 1'b1;
                        // stop with trdy when frame still up
                        nxt_stop = frame_s && disc_ff;
                        nxt_st   = pts_pkg::PTS_DATA;
                        case (ofs_ff[7:2])
                            `PTS_CFG_CMDSTAT: nxt_rdata = {8'h0, 8'h80, 14'h0, cmd_ff};
                            `PTS_CFG_IOBAR:   nxt_rdata = {iobar_ff[31:5], 5'h01};
                            `PTS_CFG_MEMBAR:  nxt_rdata = {membar_ff[31:12], 12'h000};
                            default:          nxt_rdata = 32'h0000_0000;
                        endcase
                        if (wr_ff) begin
                            case (ofs_ff[7:2])
                                `PTS_CFG_CMDSTAT: if (cbe_s[0]) nxt_cmd = ad_s[1:0];
                                `PTS_CFG_IOBAR: begin
                                    for (int b = 0; b < 4; b++) if (cbe_s[b]) nxt_iobar[b*8 +: 8] = ad_s[b*8 +: 8];
                                end
                                `PTS_CFG_MEMBAR: begin
                                    for (int b = 0; b < 4; b++) if (cbe_s[b]) nxt_membar[b*8 +: 8] = ad_s[b*8 +: 8];
                                end
                                default: nxt_cmd = cmd_ff;
                            endcase
                        end
                    end
                end else if (reg_ack) begin
                    // back end sets the wait states
                    nxt_trdy  = 1'b1;
                    nxt_stop  = frame_s && disc_ff;
                    nxt_rdata = reg_rdata;
                    nxt_st    = pts_pkg::PTS_DATA;
                    // reading reset register fires its side effect
                    nxt_srst  = !wr_ff && ofs_ff == (dword_io_mode ? `PTS_SOFT_RESET_DW : `PTS_SOFT_RESET_OFS);
                end
            end
            pts_pkg::PTS_DATA: begin
                if (!irdy_s) begin
                    nxt_trdy = 1'b1;  // master still waiting
                end else if (!frame_s) begin
                    nxt_st   = pts_pkg::PTS_TURN;
                    nxt_stop = 1'b0;
                end else if (disc_ff || stop_ff) begin
                    nxt_stop = 1'b1;
                    nxt_st   = pts_pkg::PTS_STOP;
                end else begin
                    // burst above indirect area: next data phase
                    nxt_ofs = ofs_ff + 12'h004;
                    nxt_cnt = 5'd0;
                    nxt_st  = pts_pkg::PTS_WAIT;
                end
            end
            pts_pkg::PTS_STOP: begin
                // stop stays until master drops frame
                if (!frame_s) begin
                    nxt_stop = 1'b0;
                    nxt_st   = pts_pkg::PTS_TURN;
                end
            end
            pts_pkg::PTS_TURN: begin
                nxt_devsel = 1'b0;
                nxt_stop   = 1'b0;
                nxt_oe     = 1'b0;
                nxt_retry  = 1'b0;
                nxt_st     = pts_pkg::PTS_IDLE;
            end
            default: nxt_st = pts_pkg::PTS_IDLE;
        endcase
    end

    // registers only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_ff      <= pts_pkg::PTS_IDLE;
            sp_ff      <= pts_pkg::PTS_SP_CFG;
            frame_d_ff <= 1'b0;
            wr_ff      <= 1'b0;
            ofs_ff     <= 12'h000;
            cnt_ff     <= 5'd0;
            retry_ff   <= 1'b0;
            disc_ff    <= 1'b0;
            cmd_ff     <= `PTS_CMD_RESET;
            iobar_ff   <= `PTS_BAR_RESET;
            membar_ff  <= `PTS_BAR_RESET;
            rdata_ff   <= 32'h0000_0000;
            devsel_ff  <= 1'b0;
            trdy_ff    <= 1'b0;
            stop_ff    <= 1'b0;
            oe_ff      <= 1'b0;
            srst_ff    <= 1'b0;
        end else begin
            st_ff      <= nxt_st;
            sp_ff      <= nxt_sp;
            frame_d_ff <= nxt_frame_d;
            wr_ff      <= nxt_wr;
            ofs_ff     <= nxt_ofs;
            cnt_ff     <= nxt_cnt;
            retry_ff   <= nxt_retry;
            disc_ff    <= nxt_disc;
            cmd_ff     <= nxt_cmd;
            iobar_ff   <= nxt_iobar;
            membar_ff  <= nxt_membar;
            rdata_ff   <= nxt_rdata;
            devsel_ff  <= nxt_devsel;
            trdy_ff    <= nxt_trdy;
            stop_ff    <= nxt_stop;
            oe_ff      <= nxt_oe;
            srst_ff    <= nxt_srst;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // register back end request: held while waiting on io or memory space
    assign reg_req   = st_ff == pts_pkg::PTS_WAIT && sp_ff != pts_pkg::PTS_SP_CFG && !retry_ff;
    assign reg_wr    = wr_ff;
    assign reg_mem   = sp_ff == pts_pkg::PTS_SP_MEM;
    assign reg_addr  = ofs_ff;
    assign reg_be    = cbe_s;
    assign reg_wdata = ad_s;

    // shared control lines are driven only while the cycle is ours
    assign ad_out       = rdata_ff;
    assign ad_oe_n      = !(oe_ff && devsel_ff);
    assign devsel_n_out = !devsel_ff;
    assign trdy_n_out   = !trdy_ff;
    assign stop_n_out   = !stop_ff;
    assign devsel_oe_n  = !(devsel_ff || st_ff == pts_pkg::PTS_TURN);
    assign trdy_oe_n    = devsel_oe_n;
    assign stop_oe_n    = devsel_oe_n;

    assign soft_reset_trigger  = srst_ff;
    assign io_space_enable     = cmd_ff[`PTS_CMD_IO_SPACE_ENABLE_BIT];
    assign memory_space_enable = cmd_ff[`PTS_CMD_MEMORY_SPACE_ENABLE_BIT];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_devsel_timing: assert property (@(posedge clk_sys) disable iff (!arst_n)
        st_ff == pts_pkg::PTS_DECOD |=> devsel_ff) else $error("devsel late");
    a_retry_no_trdy: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (retry_ff && devsel_ff) |-> !trdy_ff) else $error("trdy during eeprom retry");
    a_retry_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (st_ff == pts_pkg::PTS_WAIT && retry_ff) |=> stop_ff && devsel_ff) else $error("no retry stop");
    a_busy_limit: assert property (@(posedge clk_sys) disable iff (!arst_n)
        st_ff == pts_pkg::PTS_DECOD |-> ##[1:17] (trdy_ff || stop_ff)) else $error("busy over limit");
    a_io_enable: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (st_ff == pts_pkg::PTS_DECOD && sp_ff == pts_pkg::PTS_SP_IO) |-> cmd_ff[`PTS_CMD_IO_SPACE_ENABLE_BIT])
        else $error("io claimed while disabled");
    a_cfg_length: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (st_ff == pts_pkg::PTS_DECOD && sp_ff == pts_pkg::PTS_SP_CFG && !retry_ff && irdy_s)
        |=> ##2 (trdy_ff || !irdy_s)) else $error("config trdy off");
    a_low_disc: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (trdy_ff && disc_ff && frame_s && irdy_s && st_ff == pts_pkg::PTS_DATA) |=> stop_ff)
        else $error("low offset burst not stopped");
    a_stop_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (st_ff == pts_pkg::PTS_STOP && frame_s) |=> stop_ff) else $error("stop dropped early");
    a_srst_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        srst_ff |-> !wr_ff && $past(st_ff) == pts_pkg::PTS_WAIT) else $error("reset reg on write");

    c_cfg_cycle: cover property (@(posedge clk_sys) disable iff (!arst_n)
        sp_ff == pts_pkg::PTS_SP_CFG && trdy_ff);
    c_mem_burst: cover property (@(posedge clk_sys) disable iff (!arst_n)
        sp_ff == pts_pkg::PTS_SP_MEM && trdy_ff && !disc_ff ##[1:20] trdy_ff);
    c_retry: cover property (@(posedge clk_sys) disable iff (!arst_n) retry_ff && stop_ff);
endmodule

// ### testbench/pts_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// pci bus master model
// ----------------------------------------
module pts_host_model (
    input  wire logic        clk_sys,
    input  wire logic        devsel_n_out,
    input  wire logic        trdy_n_out,
    input  wire logic        stop_n_out,
    input  wire logic        ad_oe_n,
    input  wire logic [31:0] ad_out,
    output logic             frame_n,
    output logic             irdy_n,
    output logic             idsel,
    output logic      [3:0]  cbe_n,
    output logic      [31:0] ad_in
);
    logic        drv;
    logic [31:0] hold;
    // a released bus shows the inverse so stale data never looks valid
    assign ad_in = !ad_oe_n ? ad_out : (drv ? hold : ~hold);
    initial begin
        frame_n = 1'b1;
        irdy_n  = 1'b1;
        idsel   = 1'b0;
        cbe_n   = 4'hf;
        drv     = 1'b0;
        hold    = 32'h0;
    end
    // one transaction; term is {timeout, stop, trdy, devsel}
    task automatic cycle(
        input  logic [3:0]  cmd,
        input  logic [31:0] addr,
        input  logic        sel,
        input  logic [31:0] wd,
        input  logic        burst,
        output logic [31:0] rd,
        output logic [3:0]  term
    );
        int   n;
        logic done;
        term = 4'h0;
        rd   = 32'h0;
        done = 1'b0;
        @(negedge clk_sys);
        frame_n = 1'b0;
        cbe_n   = cmd;
        hold    = addr;
        drv     = 1'b1;
        idsel   = sel;
        @(negedge clk_sys);
        frame_n = !burst;
        irdy_n  = 1'b0;
        cbe_n   = 4'h0;
        idsel   = 1'b0;
        drv     = cmd[0];
        if (cmd[0]) hold = wd;
        // master abort if nobody claims within nine clocks
        for (n = 0; n < 40 && !done; n++) begin
            @(posedge clk_sys);
            if (devsel_n_out === 1'b0) term[0] = 1'b1;
            if (trdy_n_out === 1'b0) begin
                term[1] = 1'b1;
                rd      = ad_in;
            end
            if (stop_n_out === 1'b0) term[2] = 1'b1;
            done = term[1] || term[2] || (n == 8 && !term[0]);
        end
        term[3] = !done;
        @(negedge clk_sys);
        irdy_n  = frame_n;
        frame_n = 1'b1;
        drv     = 1'b0;
        @(negedge clk_sys);
        irdy_n  = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask
endmodule

// ### testbench/test_pci_target_slave_decode.sv
`timescale 1ns/1ps
`include "pts_consts.svh"
module test_pci_target_slave_decode;
    logic        clk_sys = 1'b0;
    logic        arst_n, frame_n, irdy_n, idsel, ad_oe_n, eeprom_busy, dword_io_mode;
    logic [3:0]  cbe_n, reg_be, term;
    logic [31:0] ad_in, ad_out, reg_wdata, reg_rdata, rd, exp_rd, got_wd, io_base, mem_base, wd;
    logic        devsel_n_out, devsel_oe_n, trdy_n_out, trdy_oe_n, stop_n_out, stop_oe_n;
    logic        reg_req, reg_wr, reg_mem, reg_ack, soft_reset_trigger, io_space_enable, memory_space_enable;
    logic [11:0] reg_addr, ofs;
    logic [17:0] got_ad;
    logic        wr;
    logic [31:0] wa [6];
    int          fail_count, checked, bcnt, bdly, pulses, i;

    always #2 clk_sys = ~clk_sys;

    pts_target u_pts_target (.clk_sys(clk_sys), .arst_n(arst_n), .frame_n(frame_n), .irdy_n(irdy_n),
        .idsel(idsel), .cbe_n(cbe_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
        .devsel_n_out(devsel_n_out), .devsel_oe_n(devsel_oe_n), .trdy_n_out(trdy_n_out),
        .trdy_oe_n(trdy_oe_n), .stop_n_out(stop_n_out), .stop_oe_n(stop_oe_n), .eeprom_busy(eeprom_busy),
        .reg_req(reg_req), .reg_wr(reg_wr), .reg_mem(reg_mem), .reg_addr(reg_addr), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
        .soft_reset_trigger(soft_reset_trigger), .io_space_enable(io_space_enable),
        .memory_space_enable(memory_space_enable), .dword_io_mode(dword_io_mode));
    pts_host_model u_pts_host_model (.clk_sys(clk_sys), .devsel_n_out(devsel_n_out), .trdy_n_out(trdy_n_out),
        .stop_n_out(stop_n_out), .ad_oe_n(ad_oe_n), .ad_out(ad_out), .frame_n(frame_n), .irdy_n(irdy_n),
        .idsel(idsel), .cbe_n(cbe_n), .ad_in(ad_in));

    // ----------------------------------------
    // register back end and pulse counter
    // ----------------------------------------
    // a delay above the busy limit makes the target give up first
    always @(negedge clk_sys) begin
        reg_ack <= 1'b0;
        if (reg_req !== 1'b1) begin
            bcnt <= 0;
        end else if (bcnt == bdly) begin
            exp_rd = $urandom;
            reg_rdata <= exp_rd;
            reg_ack   <= 1'b1;
            got_wd    <= reg_wdata;
            got_ad    <= {reg_mem, reg_wr, reg_be, reg_addr};
            bcnt      <= 255;
        end else if (bcnt != 255) begin
            bcnt <= bcnt + 1;
        end
    end
    always @(posedge clk_sys) begin
        if (soft_reset_trigger === 1'b1) pulses <= pulses + 1;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic fits(input logic [3:0] c, input logic mem);
        return mem ? (c == 4'h6 || c == 4'h7 || c == 4'hc || c == 4'he || c == 4'hf) : (c == 4'h2 || c == 4'h3);
    endfunction
    task automatic summarize;
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [3:0] c, input logic [31:0] a, input logic s, input logic b);
        u_pts_host_model.cycle(c, a, s, wd, b, rd, term);
        if (term[3] !== 1'b0) begin
            fail_count++;
            summarize;
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        summarize;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {arst_n, reg_ack, dword_io_mode, fail_count, checked, pulses, bcnt} = '0;
        {eeprom_busy, reg_rdata, exp_rd, got_wd, wd} = {1'b1, 128'h0};
        bdly = 2;
        void'($urandom(81));
        io_base  = {16'h0001, 11'($urandom), 5'h0};
        mem_base = {1'b1, 19'($urandom), 12'h0};
        repeat (4) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({io_space_enable, memory_space_enable, devsel_n_out, trdy_n_out, stop_n_out, devsel_oe_n}, 32'hf);
        run(`PTS_CMD_CFG_RD, 32'h4, 1'b1, 1'b0);
        chk(term, 32'h5);
        eeprom_busy = 1'b0;
        repeat (4) @(negedge clk_sys);
        run(`PTS_CMD_CFG_RD, 32'h4, 1'b0, 1'b0);
        chk(term, 32'h0);
        run(`PTS_CMD_CFG_RD, 32'h5, 1'b1, 1'b0);
        chk(term, 32'h0);
        run(`PTS_CMD_CFG_RD, 32'h104, 1'b1, 1'b0);
        chk(term, 32'h0);
        run(`PTS_CMD_CFG_RD, 32'hffff_f804, 1'b1, 1'b0);
        chk(term, 32'h3);
        chk(rd[`PTS_STAT_FBB_BIT], 32'h1);
        run(`PTS_CMD_IO_RD, io_base, 1'b0, 1'b0);
        chk(term, 32'h0);
        // program both windows, then both space enables
        wd = io_base;
        run(`PTS_CMD_CFG_WR, 32'h10, 1'b1, 1'b0);
        wd = mem_base;
        run(`PTS_CMD_CFG_WR, 32'h14, 1'b1, 1'b0);
        wd = 32'h3;
        run(`PTS_CMD_CFG_WR, 32'h4, 1'b1, 1'b0);
        chk(term, 32'h3);
        chk({io_space_enable, memory_space_enable}, 32'h3);
        wd = io_base;
        run(`PTS_CMD_CFG_WR, 32'h10, 1'b1, 1'b1);
        chk(term, 32'h7);
        // every command code against both windows
        for (i = 0; i < 16; i++) begin
            wd = $urandom;
            run(4'(i), io_base + 32'h8, 1'b0, 1'b0);
            chk(term[0], fits(4'(i), 1'b0));
            run(4'(i), mem_base + 32'h40, 1'b0, 1'b0);
            chk(term[0], fits(4'(i), 1'b1));
        end
        // window edges, first three in io space
        wa = '{io_base + 32'h1c, io_base + 32'h20, io_base - 32'h4,
               mem_base + 32'hffc, mem_base + 32'h1000, mem_base - 32'h4};
        for (i = 0; i < 6; i++) begin
            run(i < 3 ? `PTS_CMD_IO_RD : `PTS_CMD_MEM_RD, wa[i], 1'b0, 1'b0);
            chk(term[0], 32'(i == 0 || i == 3));
        end
        // reset register moves with the dword mode
        run(`PTS_CMD_IO_RD, io_base + `PTS_SOFT_RESET_OFS, 1'b0, 1'b0);
        chk(pulses, 32'h1);
        dword_io_mode = 1'b1;
        run(`PTS_CMD_IO_RD, io_base + `PTS_SOFT_RESET_OFS, 1'b0, 1'b0);
        chk(pulses, 32'h1);
        run(`PTS_CMD_IO_RD, io_base + `PTS_SOFT_RESET_DW, 1'b0, 1'b0);
        chk(pulses, 32'h2);
        run(`PTS_CMD_IO_WR, io_base + `PTS_SOFT_RESET_DW, 1'b0, 1'b0);
        chk(pulses, 32'h2);
        dword_io_mode = 1'b0;
        run(`PTS_CMD_IO_WR, io_base + 32'h4, 1'b0, 1'b1);
        chk(term, 32'h7);
        bdly = 40;
        run(`PTS_CMD_MEM_RD, mem_base + 32'h100, 1'b0, 1'b0);
        chk(term, 32'h5);
        bdly = 2;
        repeat (50) @(negedge clk_sys);
        // random register traffic above the indirect area
        for (i = 0; i < 12; i++) begin
            bdly = $urandom_range(6, 0);
            wr   = 1'($urandom);
            wd   = $urandom;
            ofs  = 12'($urandom_range(32'hffc, 32'h20)) & 12'hffc;
            run(wr ? `PTS_CMD_MEM_WR : `PTS_CMD_MEM_RD, mem_base + {20'h0, ofs}, 1'b0, 1'b0);
            chk(term, 32'h3);
            chk(wr ? got_wd : rd, wr ? wd : exp_rd);
            chk({14'h0, got_ad}, {14'h0, 1'b1, wr, 4'hf, ofs});
        end
        summarize;
    end
endmodule
